// >>> hw/tsc_link_if.sv
// carrier between the link-side byte engine and the sensor core
`timescale 1ns/100ps
interface tsc_link_if;
	logic       wrTog;
	logic       cmdTog;
	logic [7:0] cmdByte;
	logic [7:0] dataByte;
	logic [7:0] rdByte;
	logic       linkRstN;

	modport link (
		output wrTog,
		output cmdTog,
		output cmdByte,
		output dataByte,
		input  rdByte,
		input  linkRstN
	);

	modport core (
		input  wrTog,
		input  cmdTog,
		input  cmdByte,
		input  dataByte,
		output rdByte,
		output linkRstN
	);
endinterface

// >>> hw/tsc_pkg.sv
// constants and types shared by the thermal sensor configuration block
package tsc_pkg;

	// ----------------------------------------------------------------
	// link addressing and command codes
	// ----------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR   = 7'h4e;
	localparam logic [7:0] CMD_LOCAL_T  = 8'h00;
	localparam logic [7:0] CMD_REMOTE_T = 8'h01;
	localparam logic [7:0] CMD_STATUS   = 8'h02;
	localparam logic [7:0] CMD_CONFIG   = 8'h03;
	localparam logic [7:0] CMD_HI_LIM   = 8'h07;
	localparam logic [7:0] CMD_LO_LIM   = 8'h08;
	localparam logic [7:0] CMD_ONESHOT  = 8'h0f;
	localparam logic [3:0] BYTE_BITS    = 4'h8;

	// ----------------------------------------------------------------
	// sensor_mode_config fields and reset values
	// ----------------------------------------------------------------
	localparam int         CFG_MASK_BIT = 7;
	localparam int         CFG_HALT_BIT = 6;
	localparam logic [7:0] CFG_RESET    = 8'h00;
	localparam logic [7:0] HI_LIM_RESET = 8'h46;
	localparam logic [7:0] LO_LIM_RESET = 8'h00;

	// ----------------------------------------------------------------
	// status byte fields
	// ----------------------------------------------------------------
	localparam int ST_BUSY_BIT   = 7;
	localparam int ST_LOC_HI_BIT = 6;
	localparam int ST_LOC_LO_BIT = 5;
	localparam int ST_REM_HI_BIT = 4;
	localparam int ST_REM_LO_BIT = 3;

	// ----------------------------------------------------------------
	// conversion timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ  = 20;
	localparam int CONV_TIME_US = 100;
	localparam int CONV_CYCLES  = CONV_TIME_US * SYS_CLK_MHZ;

	// ----------------------------------------------------------------
	// state encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CONV_STANDBY = 2'h0,
		CONV_SINGLE  = 2'h1,
		CONV_AUTO    = 2'h3
	} tsc_conv_state_type;

	typedef enum logic [2:0] {
		PH_IGNORE = 3'h0,
		PH_ADDR   = 3'h1,
		PH_CMD    = 3'h3,
		PH_WDATA  = 3'h2,
		PH_RDATA  = 3'h6
	} tsc_link_phase_type;

endpackage

// >>> hw/tsc_smbus_link.sv
// smbus slave byte engine running on the link clock
`timescale 1ns/100ps
module tsc_smbus_link (
	input  wire logic smbClk,
	input  wire logic sdaIn,
	output logic      sdaOe,
	tsc_link_if.link  lnk
);

	typedef struct packed {
		logic                        startSeen;
		logic [3:0]                  bitCnt;
		logic [7:0]                  rxShift;
		logic [7:0]                  txShift;
		tsc_pkg::tsc_link_phase_type phase;
		logic                        wrTog;
		logic                        cmdTog;
		logic [7:0]                  cmdByte;
		logic [7:0]                  dataByte;
	} tsc_link_state_type;

	tsc_link_state_type cur_ff;
	tsc_link_state_type nxt_cur;
	logic               startTog_ff;
	logic               sdaOe_ff;
	logic               nxt_sdaOe;
	logic               addrHit;

	// ----------------------------------------------------------------
	// start condition: data falls while clock is high
	// ----------------------------------------------------------------
	always_ff @(negedge sdaIn or negedge lnk.linkRstN) begin
		if (!lnk.linkRstN) begin
			startTog_ff <= 1'b0;
		end else if (smbClk) begin
			startTog_ff <= ~startTog_ff;
		end
	end

	// ----------------------------------------------------------------
	// bit sampling on rising clock
	// ----------------------------------------------------------------
	assign addrHit = (cur_ff.rxShift[7:1] == tsc_pkg::SLAVE_ADDR);

	always_comb begin
		nxt_cur = cur_ff;
		if (startTog_ff != cur_ff.startSeen) begin
			nxt_cur.startSeen = startTog_ff;
			nxt_cur.bitCnt    = 4'h1;
			nxt_cur.rxShift   = {7'h00, sdaIn};
			nxt_cur.phase     = tsc_pkg::PH_ADDR;
		end else if (cur_ff.bitCnt != tsc_pkg::BYTE_BITS) begin
			nxt_cur.bitCnt  = cur_ff.bitCnt + 4'h1;
			nxt_cur.rxShift = {cur_ff.rxShift[6:0], sdaIn};
			if (cur_ff.phase == tsc_pkg::PH_RDATA) begin
				nxt_cur.txShift = {cur_ff.txShift[6:0], 1'b0};
			end
		end else begin
			nxt_cur.bitCnt = 4'h0;
			case (cur_ff.phase)
				tsc_pkg::PH_ADDR: begin
					if (addrHit) begin
						nxt_cur.phase   = cur_ff.rxShift[0] ?
							tsc_pkg::PH_RDATA : tsc_pkg::PH_CMD;
						nxt_cur.txShift = lnk.rdByte;
					end else begin
						nxt_cur.phase = tsc_pkg::PH_IGNORE;
					end
				end
				tsc_pkg::PH_CMD: begin
					nxt_cur.cmdByte = cur_ff.rxShift;
					nxt_cur.cmdTog  = ~cur_ff.cmdTog;
					nxt_cur.phase   = tsc_pkg::PH_WDATA;
				end
				tsc_pkg::PH_WDATA: begin
					nxt_cur.dataByte = cur_ff.rxShift;
					nxt_cur.wrTog    = ~cur_ff.wrTog;
				end
				tsc_pkg::PH_RDATA: begin
					// master ack repeats the byte, nack ends it
					if (!sdaIn) begin
						nxt_cur.txShift = lnk.rdByte;
					end else begin
						nxt_cur.phase = tsc_pkg::PH_IGNORE;
					end
				end
				default: begin
					nxt_cur.phase = tsc_pkg::PH_IGNORE;
				end
			endcase
		end
	end

	always_ff @(posedge smbClk or negedge lnk.linkRstN) begin
		if (!lnk.linkRstN) begin
			cur_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	// ----------------------------------------------------------------
	// data drive changes on falling clock
	// ----------------------------------------------------------------
	always_comb begin
		nxt_sdaOe = 1'b0;
		if (cur_ff.bitCnt == tsc_pkg::BYTE_BITS) begin
			nxt_sdaOe = (cur_ff.phase == tsc_pkg::PH_ADDR && addrHit) ||
				cur_ff.phase == tsc_pkg::PH_CMD ||
				cur_ff.phase == tsc_pkg::PH_WDATA;
		end else if (cur_ff.phase == tsc_pkg::PH_RDATA) begin
			nxt_sdaOe = ~cur_ff.txShift[7];
		end
	end

	always_ff @(negedge smbClk or negedge lnk.linkRstN) begin
		if (!lnk.linkRstN) begin
			sdaOe_ff <= 1'b0;
		end else begin
			sdaOe_ff <= nxt_sdaOe;
		end
	end

	assign sdaOe        = sdaOe_ff;
	assign lnk.wrTog    = cur_ff.wrTog;
	assign lnk.cmdTog   = cur_ff.cmdTog;
	assign lnk.cmdByte  = cur_ff.cmdByte;
	assign lnk.dataByte = cur_ff.dataByte;

endmodule

// >>> hw/tsc_thermal_sensor.sv
// thermal sensor mode control, conversion engine and alert logic
`timescale 1ns/100ps

// Function
// - answer as link slave only at seven-bit address 1001110; other addresses get no ack.
// - halt bit 6 low keeps the sensor converting continuously.
// - writing halt bit 6 high aborts a continuous conversion and enters standby; a one-shot runs on.
// - in standby each one-shot command runs exactly one conversion.
// - mask bit 7 high suppresses the alert output; low allows it.
// - unmasked alert asserts while either temperature lies beyond a threshold.
module tsc_thermal_sensor #(
	parameter int CONV_CYC = tsc_pkg::CONV_CYCLES
) (
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	input  wire logic       smbClk,
	input  wire logic       smbDataIn,
	output logic            smbDataOut,
	output logic            smbDataOe,
	output logic            alertOut,
	output logic            alertOe,
	output logic            standbyMode,
	input  wire logic [7:0] localTempIn,
	input  wire logic [7:0] remoteTempIn
);

	// ----------------------------------------------------------------
	// counter sizing and parameter check
	// ----------------------------------------------------------------
	localparam int CNT_W = $clog2(CONV_CYC);

	if (CONV_CYC < 2) begin : g_bad_conv
		$error("CONV_CYC must be at least 2");
	end

	// ----------------------------------------------------------------
	// registered state of the core
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                        lnkRstN;
		logic [2:0]                  wrSync;
		logic [2:0]                  cmdSync;
		logic                        alertMask;
		logic                        convHalt;
		logic [7:0]                  hiLim;
		logic [7:0]                  loLim;
		logic [7:0]                  localT;
		logic [7:0]                  remoteT;
		tsc_pkg::tsc_conv_state_type state;
		logic [CNT_W-1:0]            convCnt;
		logic [7:0]                  rdByte;
		logic                        alertOe;
		logic                        standby;
	} tsc_core_state_type;

	tsc_core_state_type cur_ff;
	tsc_core_state_type nxt_cur;
	tsc_link_if         lnk ();

	logic       wrEvent;
	logic       cmdEvent;
	logic       convDone;
	logic       locHi;
	logic       locLo;
	logic       remHi;
	logic       remLo;
	logic [7:0] cfgByte;
	logic [7:0] statByte;

	// ----------------------------------------------------------------
	// link-side byte engine
	// ----------------------------------------------------------------
	tsc_smbus_link u_link (
		.smbClk (smbClk),
		.sdaIn  (smbDataIn),
		.sdaOe  (smbDataOe),
		.lnk    (lnk.link)
	);

	// ----------------------------------------------------------------
	// readable views
	// ----------------------------------------------------------------
	assign locHi = $signed(cur_ff.localT) > $signed(cur_ff.hiLim);
	assign locLo = $signed(cur_ff.localT) < $signed(cur_ff.loLim);
	assign remHi = $signed(cur_ff.remoteT) > $signed(cur_ff.hiLim);
	assign remLo = $signed(cur_ff.remoteT) < $signed(cur_ff.loLim);

	always_comb begin
		cfgByte = '0;
		cfgByte[tsc_pkg::CFG_MASK_BIT] = cur_ff.alertMask;
		cfgByte[tsc_pkg::CFG_HALT_BIT] = cur_ff.convHalt;
		statByte = '0;
		statByte[tsc_pkg::ST_BUSY_BIT]   =
			cur_ff.state != tsc_pkg::CONV_STANDBY;
		statByte[tsc_pkg::ST_LOC_HI_BIT] = locHi;
		statByte[tsc_pkg::ST_LOC_LO_BIT] = locLo;
		statByte[tsc_pkg::ST_REM_HI_BIT] = remHi;
		statByte[tsc_pkg::ST_REM_LO_BIT] = remLo;
	end

	// toggles cross from the link clock; bytes beside them are stable
	assign wrEvent  = cur_ff.wrSync[2] ^ cur_ff.wrSync[1];
	assign cmdEvent = cur_ff.cmdSync[2] ^ cur_ff.cmdSync[1];
	assign convDone = cur_ff.convCnt == CNT_W'(CONV_CYC - 1);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_cur         = cur_ff;
		nxt_cur.lnkRstN = 1'b1;
		nxt_cur.wrSync  = {cur_ff.wrSync[1:0], lnk.wrTog};
		nxt_cur.cmdSync = {cur_ff.cmdSync[1:0], lnk.cmdTog};

		// register writes
		if (wrEvent) begin
			case (lnk.cmdByte)
				tsc_pkg::CMD_CONFIG: begin
					nxt_cur.alertMask =
						lnk.dataByte[tsc_pkg::CFG_MASK_BIT];
					nxt_cur.convHalt  =
						lnk.dataByte[tsc_pkg::CFG_HALT_BIT];
				end
				tsc_pkg::CMD_HI_LIM: nxt_cur.hiLim = lnk.dataByte;
				tsc_pkg::CMD_LO_LIM: nxt_cur.loLim = lnk.dataByte;
				default: ;
			endcase
		end

		// read snapshot taken when a command byte arrives
		if (cmdEvent) begin
			case (lnk.cmdByte)
				tsc_pkg::CMD_LOCAL_T:  nxt_cur.rdByte = cur_ff.localT;
				tsc_pkg::CMD_REMOTE_T: nxt_cur.rdByte = cur_ff.remoteT;
				tsc_pkg::CMD_STATUS:   nxt_cur.rdByte = statByte;
				tsc_pkg::CMD_CONFIG:   nxt_cur.rdByte = cfgByte;
				tsc_pkg::CMD_HI_LIM:   nxt_cur.rdByte = cur_ff.hiLim;
				tsc_pkg::CMD_LO_LIM:   nxt_cur.rdByte = cur_ff.loLim;
				default:               nxt_cur.rdByte = 8'h00;
			endcase
		end

		// conversion engine
		case (cur_ff.state)
			tsc_pkg::CONV_STANDBY: begin
				nxt_cur.convCnt = '0;
				if (!nxt_cur.convHalt) begin
					nxt_cur.state = tsc_pkg::CONV_AUTO;
				end else if (cmdEvent &&
					lnk.cmdByte == tsc_pkg::CMD_ONESHOT) begin
					nxt_cur.state = tsc_pkg::CONV_SINGLE;
				end
			end
			tsc_pkg::CONV_SINGLE: begin
				nxt_cur.convCnt = cur_ff.convCnt + 1'b1;
				if (convDone) begin
					nxt_cur.localT  = localTempIn;
					nxt_cur.remoteT = remoteTempIn;
					nxt_cur.convCnt = '0;
					nxt_cur.state   = tsc_pkg::CONV_STANDBY;
				end
				if (!nxt_cur.convHalt) begin
					nxt_cur.state = tsc_pkg::CONV_AUTO;
				end
			end
			tsc_pkg::CONV_AUTO: begin
				// one-shot here is ignored
				nxt_cur.convCnt = cur_ff.convCnt + 1'b1;
				if (convDone) begin
					nxt_cur.localT  = localTempIn;
					nxt_cur.remoteT = remoteTempIn;
					nxt_cur.convCnt = '0;
				end
				if (nxt_cur.convHalt) begin
					nxt_cur.localT  = cur_ff.localT;
					nxt_cur.remoteT = cur_ff.remoteT;
					nxt_cur.convCnt = '0;
					nxt_cur.state   = tsc_pkg::CONV_STANDBY;
				end
			end
			default: begin
				nxt_cur.convCnt = '0;
				nxt_cur.state   = tsc_pkg::CONV_STANDBY;
			end
		endcase

		// alert from latest results
		nxt_cur.alertOe = !nxt_cur.alertMask &&
			(locHi || locLo || remHi || remLo);

		// standby pin from a flop, same cycle as the state
		nxt_cur.standby = nxt_cur.state == tsc_pkg::CONV_STANDBY;

		if (!resetn) begin
			nxt_cur           = '0;
			nxt_cur.alertMask = tsc_pkg::CFG_RESET[tsc_pkg::CFG_MASK_BIT];
			nxt_cur.convHalt  = tsc_pkg::CFG_RESET[tsc_pkg::CFG_HALT_BIT];
			nxt_cur.hiLim     = tsc_pkg::HI_LIM_RESET;
			nxt_cur.loLim     = tsc_pkg::LO_LIM_RESET;
			nxt_cur.state     = tsc_pkg::CONV_AUTO;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		cur_ff <= nxt_cur;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign lnk.rdByte   = cur_ff.rdByte;
	assign lnk.linkRstN = cur_ff.lnkRstN;
	assign alertOe      = cur_ff.alertOe;
	assign alertOut     = 1'b0;
	assign smbDataOut   = 1'b0;
	assign standbyMode  = cur_ff.standby;

endmodule

// >>> verif/tsc_smbus_host.sv
// smbus host model; link clock runs only inside frames
`timescale 1ns/100ps
module tsc_smbus_host (
	output logic      smbClk,
	output logic      sdaLow,
	input  wire logic sdaIn
);
	initial begin
		smbClk = 1'b1;
		sdaLow = 1'b0;
	end

	// ----------------------------------------------------------------
	// bit level, 160 ns link clock
	// ----------------------------------------------------------------
	task automatic bitOut(input logic v);
		sdaLow <= !v;
		#40 smbClk <= 1'b1;
		#80 smbClk <= 1'b0;
		#40;
	endtask
	task automatic bitIn(output logic v);
		sdaLow <= 1'b0;
		#40 smbClk <= 1'b1;
		#40 v = sdaIn;
		#40 smbClk <= 1'b0;
		#40;
	endtask
	task automatic start();
		sdaLow <= 1'b0;
		#40 smbClk <= 1'b1;
		#80 sdaLow <= 1'b1;
		#80 smbClk <= 1'b0;
		#40;
	endtask
	task automatic stop();
		sdaLow <= 1'b1;
		#40 smbClk <= 1'b1;
		#80 sdaLow <= 1'b0;
		#80;
	endtask
	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic n;
		for (int i = 7; i >= 0; i--) bitOut(b[i]);
		bitIn(n);
		ack = !n;
	endtask

	// ----------------------------------------------------------------
	// frames
	// ----------------------------------------------------------------
	task automatic send(input logic [6:0] a, input logic [7:0] c, d,
		input logic wd, output logic ack);
		logic k;
		start();
		sendByte({a, 1'b0}, ack);
		if (ack) begin
			sendByte(c, k);
			if (wd) sendByte(d, k);
		end
		stop();
	endtask
	task automatic fetch(input logic [7:0] c, output logic [7:0] d);
		logic k;
		start();
		sendByte({tsc_pkg::SLAVE_ADDR, 1'b0}, k);
		sendByte(c, k);
		start();
		sendByte({tsc_pkg::SLAVE_ADDR, 1'b1}, k);
		for (int i = 7; i >= 0; i--) bitIn(d[i]);
		bitOut(1'b1);
		stop();
	endtask
endmodule

// >>> verif/tsc_thermal_sensor_checker.sv
// port assertions for the thermal sensor block
`timescale 1ns/100ps
module tsc_thermal_sensor_checker #(
	parameter int CONV_CYC = tsc_pkg::CONV_CYCLES
) (
	input logic       sys_clk,
	input logic       resetn,
	input logic       smbClk,
	input logic       smbDataIn,
	input logic       smbDataOut,
	input logic       smbDataOe,
	input logic       alertOut,
	input logic       alertOe,
	input logic       standbyMode,
	input logic [7:0] localTempIn,
	input logic [7:0] remoteTempIn
);
	logic        smbClkQ;
	logic [7:0]  linkAge;
	logic [15:0] tempQ;
	logic [15:0] tempAge;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!resetn);

	// ----------------------------------------------------------------
	// cycles since last link edge and last temperature change
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		smbClkQ <= smbClk;
		tempQ   <= {localTempIn, remoteTempIn};
		linkAge <= (smbClk != smbClkQ) ? 8'h00 :
			(!resetn || &linkAge) ? 8'hff : linkAge + 8'h01;
		tempAge <= (tempQ != {localTempIn, remoteTempIn}) ? 16'h0000 :
			(!resetn || &tempAge) ? 16'hffff : tempAge + 16'h0001;
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_data_low: assert property (smbDataOut == 1'b0)
		else $error("data drive value not low");
	a_alert_low: assert property (alertOut == 1'b0)
		else $error("alert drive value not low");
	a_ack_clk_low: assert property ($changed(smbDataOe) |-> !smbClk)
		else $error("data enable moved while link clock high");
	a_idle_release: assert property (smbClk [*8] |-> !smbDataOe)
		else $error("data held low on idle link");
	a_wake_by_link: assert property ($fell(standbyMode) |-> linkAge < 8'h28)
		else $error("standby left without link command");
	a_standby_still: assert property (
		$changed(alertOe) && standbyMode && $past(standbyMode)
		|-> linkAge < 8'h28)
		else $error("alert moved in standby without command");
	a_alert_cause: assert property (
		$changed(alertOe) && linkAge > 8'h28
		|-> tempAge <= 16'(2 * CONV_CYC + 4))
		else $error("alert moved without temperature change");
	a_reset_state: assert property (
		$rose(resetn) |-> !alertOe && !standbyMode && !smbDataOe)
		else $error("wrong state after reset");

	cover property ($fell(standbyMode));
	cover property ($rose(alertOe));
	cover property ($rose(smbDataOe));
endmodule

bind tsc_thermal_sensor tsc_thermal_sensor_checker #(.CONV_CYC(CONV_CYC))
	tsc_thermal_sensor_checker_inst (
	.sys_clk(sys_clk), .resetn(resetn), .smbClk(smbClk),
	.smbDataIn(smbDataIn), .smbDataOut(smbDataOut),
	.smbDataOe(smbDataOe), .alertOut(alertOut), .alertOe(alertOe),
	.standbyMode(standbyMode), .localTempIn(localTempIn),
	.remoteTempIn(remoteTempIn)
);

// >>> verif/tsc_thermal_sensor_tb.sv
// self-checking bench for the thermal sensor block
`timescale 1ns/100ps
module tsc_thermal_sensor_tb;
	localparam int CC = 20;
	logic       sys_clk, resetn, smbClk, sdaLow, sda, ack;
	logic       smbDataOut, smbDataOe, alertOut, alertOe, standbyMode;
	logic [7:0] localT, remoteT;
	int         errCount = 0;
	int         numChecks = 0;
	int         cycles = 0;

	assign sda = !(sdaLow || smbDataOe);
	tsc_thermal_sensor #(.CONV_CYC(CC)) tsc_thermal_sensor_inst (
		.sys_clk(sys_clk), .resetn(resetn), .smbClk(smbClk),
		.smbDataIn(sda), .smbDataOut(smbDataOut), .smbDataOe(smbDataOe),
		.alertOut(alertOut), .alertOe(alertOe), .standbyMode(standbyMode),
		.localTempIn(localT), .remoteTempIn(remoteT)
	);
	tsc_smbus_host tsc_smbus_host_inst (
		.smbClk(smbClk), .sdaLow(sdaLow), .sdaIn(sda)
	);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task end_sim();
		$display("checks %0d errors %0d", numChecks, errCount);
		if (errCount == 0 && numChecks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		numChecks++;
		if (got !== exp) begin
			errCount++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task waitc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task wcfg(input logic [7:0] v);
		tsc_smbus_host_inst.send(tsc_pkg::SLAVE_ADDR, tsc_pkg::CMD_CONFIG,
			v & 8'hc0, 1'b1, ack);
		waitc(8);
	endtask
	task wreg(input logic [7:0] c, input logic [7:0] v);
		tsc_smbus_host_inst.send(tsc_pkg::SLAVE_ADDR, c, v, 1'b1, ack);
		waitc(8);
	endtask
	task rdchk(input logic [7:0] c, input logic [7:0] exp);
		logic [7:0] d;
		tsc_smbus_host_inst.fetch(c, d);
		chk(c == tsc_pkg::CMD_CONFIG ? d & 8'hc0 : d, exp);
	endtask
	task settemp(input logic [7:0] l, input logic [7:0] r);
		@(posedge sys_clk);
		localT <= l;
		remoteT <= r;
		waitc(3 * CC);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_reset();
		chk({7'h00, standbyMode}, 8'h00);
		chk({7'h00, alertOe}, 8'h00);
		rdchk(tsc_pkg::CMD_CONFIG, tsc_pkg::CFG_RESET);
	endtask
	task t_address();
		tsc_smbus_host_inst.send(7'h4f, tsc_pkg::CMD_CONFIG, 8'hc0, 1'b1, ack);
		chk({7'h00, ack}, 8'h00);
		rdchk(tsc_pkg::CMD_CONFIG, 8'h00);
	endtask
	task automatic t_config();
		logic [7:0] v[4] = '{8'h80, 8'h40, 8'hc0, 8'h00};
		foreach (v[i]) begin
			wcfg(v[i]);
			rdchk(tsc_pkg::CMD_CONFIG, v[i]);
			chk({7'h00, standbyMode}, {7'h00, v[i][6]});
		end
	endtask
	task t_alert();
		settemp(8'h50, 8'h00);
		chk({7'h00, alertOe}, 8'h01);
		rdchk(tsc_pkg::CMD_LOCAL_T, 8'h50);
		wcfg(8'h80);
		chk({7'h00, alertOe}, 8'h00);
		settemp(8'h10, 8'h80);
		chk({7'h00, alertOe}, 8'h00);
		wcfg(8'h00);
		chk({7'h00, alertOe}, 8'h01);
		rdchk(tsc_pkg::CMD_REMOTE_T, 8'h80);
		settemp(8'h10, 8'h00);
		chk({7'h00, alertOe}, 8'h00);
	endtask
	task t_oneshot();
		wcfg(8'h40);
		settemp(8'h22, 8'h00);
		chk({7'h00, standbyMode}, 8'h01);
		rdchk(tsc_pkg::CMD_LOCAL_T, 8'h10);
		tsc_smbus_host_inst.send(tsc_pkg::SLAVE_ADDR,
			tsc_pkg::CMD_ONESHOT, 8'h00, 1'b0, ack);
		chk({7'h00, standbyMode}, 8'h00);
		waitc(CC + 8);
		rdchk(tsc_pkg::CMD_LOCAL_T, 8'h22);
		chk({7'h00, standbyMode}, 8'h01);
	endtask
	task t_limits();
		logic [7:0] hiBits;
		logic [7:0] loBits;
		hiBits = '0;
		hiBits[tsc_pkg::ST_LOC_HI_BIT] = 1'b1;
		loBits = '0;
		loBits[tsc_pkg::ST_LOC_LO_BIT] = 1'b1;
		loBits[tsc_pkg::ST_REM_LO_BIT] = 1'b1;
		// latched temps are local 0x22, remote 0x00, standby, unmasked
		wreg(tsc_pkg::CMD_HI_LIM, 8'h20);
		chk({7'h00, alertOe}, 8'h01);
		rdchk(tsc_pkg::CMD_HI_LIM, 8'h20);
		rdchk(tsc_pkg::CMD_STATUS, hiBits);
		wreg(tsc_pkg::CMD_HI_LIM, tsc_pkg::HI_LIM_RESET);
		chk({7'h00, alertOe}, 8'h00);
		wreg(tsc_pkg::CMD_LO_LIM, 8'h30);
		chk({7'h00, alertOe}, 8'h01);
		rdchk(tsc_pkg::CMD_LO_LIM, 8'h30);
		rdchk(tsc_pkg::CMD_STATUS, loBits);
		wreg(tsc_pkg::CMD_LO_LIM, tsc_pkg::LO_LIM_RESET);
		chk({7'h00, alertOe}, 8'h00);
	endtask

	initial begin
		resetn = 1'b0;
		localT = 8'h00;
		remoteT = 8'h00;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		waitc(4);
		t_reset();
		t_address();
		t_config();
		t_alert();
		t_oneshot();
		t_limits();
		end_sim();
	end
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errCount++;
			end_sim();
		end
	end
endmodule
